// ### logic/flash_row_write_latch_sequencer.sv
// flash row write latch sequencer with avalon register slave
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
module flash_row_write_latch_sequencer
	import flash_seq_pkg::*;
#(
	parameter int WORDS = 32
)(
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic [9:0]  wp_rows_in,
	output flash_cmd_t       flash_cmd_out,
	output logic             flash_req_out,
	input  wire logic        flash_ack_in,
	output logic             irq_out
);
	`include "flash_seq_regs.svh"

	localparam int IW = $clog2(WORDS);

	// elaboration check
	initial
	begin
		if (WORDS != 32)
			$error("flash_row_write_latch_sequencer: row must hold 32 latches");
	end

	// ***********************************
	// state
	// ***********************************
	logic [7:0]              addr_low_r;
	logic [`ADDR_HIGH_W-1:0] addr_high_r;
	logic [7:0]              data_low_r;
	logic [`DATA_HIGH_W-1:0] data_high_r;
	flash_ctl_t              ctl_r;
	logic [1:0]              status_r;
	logic [1:0]              status_nxt;
	logic [1:0]              mask_r;
	unlock_state_t           unlock_r;
	unlock_state_t           unlock_nxt;
	op_state_t               state_r;
	op_state_t               state_nxt;
	logic [9:0]              row_r;
	logic [IW-1:0]           idx_r;
	logic                    erase_r;
	logic                    rd_pend_r;
	logic [31:0]             rdata_r;
	flash_cmd_t              cmd_r;
	logic                    werr_nxt;

	// ***********************************
	// bus decode
	// ***********************************
	wire         wr_ok      = avs_write_in && avs_byteenable_in[0];
	wire [7:0]   wbyte      = avs_writedata_in[7:0];
	wire         wr_alow    = wr_ok && avs_address_in == `OFS_ADDR_LOW;
	wire         wr_ahigh   = wr_ok && avs_address_in == `OFS_ADDR_HIGH;
	wire         wr_dlow    = wr_ok && avs_address_in == `OFS_DATA_LOW;
	wire         wr_dhigh   = wr_ok && avs_address_in == `OFS_DATA_HIGH;
	wire         wr_ctl     = wr_ok && avs_address_in == `OFS_CONTROL;
	wire         wr_key     = wr_ok && avs_address_in == `OFS_UNLOCK_KEY;
	wire         wr_stat    = wr_ok && avs_address_in == `OFS_IRQ_STATUS;
	wire         wr_mask    = wr_ok && avs_address_in == `OFS_IRQ_MASK;
	wire         busy       = state_r != S_IDLE;
	wire [14:0]  full_addr  = {addr_high_r, addr_low_r};
	wire [9:0]   sel_row    = full_addr[14:`ROW_LSB];
	wire [IW-1:0] sel_latch = addr_low_r[IW-1:0];
	wire [13:0]  data_word  = {data_high_r, data_low_r};

	// write start only counts right after the two keys, with writes enabled
	wire ws_write  = wr_ctl && wbyte[`CTL_WRITE_START] && !busy;
	wire ws_armed  = ws_write && unlock_r == U_GOTAA && wbyte[`CTL_WRITE_EN];
	wire load_only = wbyte[`CTL_LOAD_ONLY] && !wbyte[`CTL_ROW_ERASE];
	// user ids are the only writable part of the configuration region
	wire protected_hit = wbyte[`CTL_REGION_SEL] ? (full_addr > `USER_ID_LAST)
	                                            : (sel_row < wp_rows_in);
	// latch loads never touch the array, so protection is ignored for them
	wire start_op  = ws_armed && (load_only || !protected_hit);
	wire wp_refuse = ws_armed && !load_only && protected_hit;

	// ***********************************
	// unlock tracker
	// ***********************************
	always_comb
	begin
		unlock_nxt = U_IDLE;
		case (unlock_r)
			U_IDLE:  unlock_nxt = (wr_key && wbyte == `UNLOCK_KEY_1) ? U_GOT55 : U_IDLE;
			U_GOT55: unlock_nxt = !avs_write_in ? U_GOT55
			                    : (wr_key && wbyte == `UNLOCK_KEY_2) ? U_GOTAA
			                    : U_IDLE;
			U_GOTAA: unlock_nxt = !avs_write_in ? U_GOTAA : U_IDLE;
			default: unlock_nxt = U_IDLE;
		endcase
	end

	wire key_break = (unlock_r == U_GOT55 && avs_write_in
	                  && !(wr_key && wbyte == `UNLOCK_KEY_2))
	                 || (unlock_r == U_GOTAA && avs_write_in && !ws_armed);

	// ***********************************
	// operation sequencer
	// ***********************************
	wire [IW-1:0]   latch_rd_idx;
	wire [13:0]     latch_rd_data;
	wire [WORDS-1:0] loaded;
	wire last_idx   = idx_r == `LAST_IDX;
	wire prog_hit   = loaded[idx_r];
	wire op_done    = state_r == S_WAIT && flash_ack_in && (erase_r || last_idx);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:   if (start_op)
			              state_nxt = wbyte[`CTL_ROW_ERASE] ? S_PROG : S_LOAD;
			S_LOAD:   state_nxt = ctl_r.load_only ? S_IDLE : S_PROG;
			S_PROG:   if (erase_r || prog_hit)
			              state_nxt = S_WAIT;
			          else if (last_idx)
			              state_nxt = S_FINISH;
			S_WAIT:   if (op_done)
			              state_nxt = S_FINISH;
			          else if (flash_ack_in)
			              state_nxt = S_PROG;
			S_FINISH: state_nxt = S_IDLE;
			default:  state_nxt = S_IDLE;
		endcase
	end

	// words of the row, walked in index order
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			idx_r <= `RST_IDX;
		else if (state_r == S_IDLE)
			idx_r <= `RST_IDX;
		else if ((state_r == S_PROG && !erase_r && !prog_hit && !last_idx)
		         || (state_r == S_WAIT && flash_ack_in && !last_idx))
			idx_r <= idx_r + IW'(1);
	end

	// row and kind are frozen at start so later address writes cannot move them
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r <= S_IDLE;
			row_r   <= `RST_ROW;
			erase_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (start_op)
			begin
				row_r   <= sel_row;
				erase_r <= wbyte[`CTL_ROW_ERASE];
			end
		end
	end

	// command to the array, erase always on the row boundary
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			cmd_r <= '0;
		else if (state_r == S_PROG)
		begin
			cmd_r.erase  <= erase_r;
			cmd_r.region <= ctl_r.region_sel;
			cmd_r.addr   <= {row_r, erase_r ? `RST_IDX : idx_r};
			cmd_r.data   <= latch_rd_data;
		end
	end

	assign latch_rd_idx  = idx_r;
	assign flash_cmd_out = cmd_r;
	assign flash_req_out = state_r == S_WAIT;

	latch_bank #(
		.WORDS (WORDS),
		.WIDTH (14)
	) u_latches (
		.clk_in       (clk_in),
		.resetn_in    (resetn_in),
		.load_en_in   (state_r == S_LOAD),
		.load_idx_in  (sel_latch),
		.load_data_in (data_word),
		.clear_in     (state_r == S_FINISH),
		.rd_idx_in    (latch_rd_idx),
		.rd_data_out  (latch_rd_data),
		.loaded_out   (loaded)
	);

	// ***********************************
	// registers
	// ***********************************
	// hardware set wins over a software clear in the same cycle
	assign werr_nxt = wp_refuse || key_break
	                  || (wr_ctl ? wbyte[`CTL_WRITE_ERR] : ctl_r.write_err);

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			addr_low_r  <= `RST_BYTE;
			addr_high_r <= '0;
			data_low_r  <= `RST_BYTE;
			data_high_r <= '0;
			ctl_r       <= '0;
		end
		else
		begin
			if (wr_alow)
				addr_low_r <= wbyte;
			if (wr_ahigh)
				addr_high_r <= wbyte[`ADDR_HIGH_W-1:0];
			if (wr_dlow)
				data_low_r <= wbyte;
			if (wr_dhigh)
				data_high_r <= wbyte[`DATA_HIGH_W-1:0];
			if (wr_ctl)
			begin
				ctl_r.region_sel <= wbyte[`CTL_REGION_SEL];
				ctl_r.load_only  <= wbyte[`CTL_LOAD_ONLY];
				ctl_r.row_erase  <= wbyte[`CTL_ROW_ERASE];
				ctl_r.write_en   <= wbyte[`CTL_WRITE_EN];
			end
			ctl_r.write_err <= werr_nxt;
		end
	end

	// ***********************************
	// interrupts
	// ***********************************
	// sticky events, write one to clear, set beats clear
	assign status_nxt = (status_r & ~(wr_stat ? wbyte[1:0] : `RST_IRQ))
	                    | {wp_refuse || key_break, op_done && erase_r
	                       || state_r == S_FINISH};

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			status_r <= `RST_IRQ;
			mask_r   <= `RST_IRQ;
			unlock_r <= U_IDLE;
		end
		else
		begin
			status_r <= status_nxt;
			unlock_r <= unlock_nxt;
			if (wr_mask)
				mask_r <= wbyte[1:0];
		end
	end

	assign irq_out = |(status_r & mask_r);

	// ***********************************
	// read path
	// ***********************************
	// one wait cycle on reads so the data word comes from a flop
	wire [7:0] ctl_byte = {1'b0, ctl_r.region_sel, ctl_r.load_only, ctl_r.row_erase,
	                       ctl_r.write_err, ctl_r.write_en, busy, 1'b0};
	wire [7:0] rd_byte  =
		avs_address_in == `OFS_ADDR_LOW   ? addr_low_r :
		avs_address_in == `OFS_ADDR_HIGH  ? {1'b0, addr_high_r} :
		avs_address_in == `OFS_DATA_LOW   ? data_low_r :
		avs_address_in == `OFS_DATA_HIGH  ? {2'b00, data_high_r} :
		avs_address_in == `OFS_CONTROL    ? ctl_byte :
		avs_address_in == `OFS_IRQ_STATUS ? {6'h00, status_r} :
		avs_address_in == `OFS_IRQ_MASK   ? {6'h00, mask_r} : `RST_BYTE;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rd_pend_r <= 1'b0;
			rdata_r   <= '0;
		end
		else
		begin
			rd_pend_r <= avs_read_in && !rd_pend_r;
			if (avs_read_in && !rd_pend_r)
				rdata_r <= {24'h000000, rd_byte};
		end
	end

	assign avs_readdata_out    = rdata_r;
	assign avs_waitrequest_out = avs_read_in && !rd_pend_r;

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	unlock_order_a: assert property (start_op |-> unlock_r == U_GOTAA
		&& $past(unlock_r) != U_IDLE)
		else $error("operation started without both keys");
	no_start_a: assert property (state_r == S_IDLE && !ws_armed |=> state_r == S_IDLE)
		else $error("operation started without full unlock");
	blank_after_a: assert property (state_r == S_FINISH |=> loaded == '0
		&& latch_rd_data == `LATCH_BLANK)
		else $error("latches not blank after operation");
	load_only_a: assert property (start_op && load_only |=> state_r == S_LOAD
		##1 state_r == S_IDLE && !flash_req_out)
		else $error("load only started programming");
	prog_after_a: assert property (state_r == S_LOAD && !ctl_r.load_only
		|=> state_r == S_PROG && loaded != '0)
		else $error("final load did not start programming");
	same_row_a: assert property (flash_req_out |-> cmd_r.addr[14:5] == row_r)
		else $error("command left the addressed row");
	erase_bound_a: assert property (flash_req_out && cmd_r.erase |-> cmd_r.addr[4:0] == 5'h00)
		else $error("erase not on row boundary");
	done_flag_a: assert property (state_r == S_FINISH && !$past(state_r == S_LOAD)
		|=> status_r[`IRQ_DONE_BIT])
		else $error("done flag not set on completion");
	wp_err_a: assert property (wp_refuse |=> ctl_r.write_err && state_r == S_IDLE)
		else $error("protected write not flagged");
	busy_bit_a: assert property (start_op && load_only |=> ctl_byte[`CTL_WRITE_START]
		##1 !ctl_byte[`CTL_WRITE_START])
		else $error("write start bit did not follow the load");

	load_cov_c:  cover property (start_op && load_only ##1 state_r == S_LOAD);
	prog_cov_c:  cover property (state_r == S_WAIT && flash_ack_in && last_idx);
	erase_cov_c: cover property (flash_req_out && cmd_r.erase);
	break_cov_c: cover property (unlock_r == U_GOTAA && avs_write_in && !ws_armed);

endmodule

// ### common/flash_seq_regs.svh
// register offsets, field positions, key values and reset values of the flash sequencer
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// ***********************************
// register byte offsets
// ***********************************
`define OFS_ADDR_LOW    5'h00
`define OFS_ADDR_HIGH   5'h04
`define OFS_DATA_LOW    5'h08
`define OFS_DATA_HIGH   5'h0C
`define OFS_CONTROL     5'h10
`define OFS_UNLOCK_KEY  5'h14
`define OFS_IRQ_STATUS  5'h18
`define OFS_IRQ_MASK    5'h1C

// ***********************************
// control register bit positions
// ***********************************
`define CTL_WRITE_START 1
`define CTL_WRITE_EN    2
`define CTL_WRITE_ERR   3
`define CTL_ROW_ERASE   4
`define CTL_LOAD_ONLY   5
`define CTL_REGION_SEL  6

// ***********************************
// status and mask bit positions
// ***********************************
`define IRQ_DONE_BIT    0
`define IRQ_ERR_BIT     1

// ***********************************
// keys, blank value, resets
// ***********************************
`define UNLOCK_KEY_1    8'h55
`define UNLOCK_KEY_2    8'hAA
`define LATCH_BLANK     14'h3FFF
`define ADDR_HIGH_W     7
`define DATA_HIGH_W     6
`define USER_ID_LAST    15'h0003
`define RST_BYTE        8'h00
`define RST_IRQ         2'h0
`define RST_ROW         10'h000
`define RST_IDX         5'h00
`define LAST_IDX        5'h1F
`define ROW_LSB         5

`endif

// ### common/flash_seq_pkg.sv
// types shared by the flash row write sequencer
package flash_seq_pkg;

	// unlock key tracker
	typedef enum logic [1:0] {
		U_IDLE  = 2'b00,
		U_GOT55 = 2'b01,
		U_GOTAA = 2'b10
	} unlock_state_t;

	// operation sequencer
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_LOAD   = 3'b001,
		S_PROG   = 3'b010,
		S_WAIT   = 3'b011,
		S_FINISH = 3'b100
	} op_state_t;

	// one command to the flash array
	typedef struct packed {
		logic        erase;
		logic        region;
		logic [14:0] addr;
		logic [13:0] data;
	} flash_cmd_t;

	// control register fields
	typedef struct packed {
		logic region_sel;
		logic load_only;
		logic row_erase;
		logic write_err;
		logic write_en;
	} flash_ctl_t;

endpackage

// ### logic/latch_bank.sv
// bank of row write latches with per-latch loaded marks
`timescale 1ns/1ns
module latch_bank
	import flash_seq_pkg::*;
#(
	parameter int WORDS = 32,
	parameter int WIDTH = 14
)(
	input  wire logic                     clk_in,
	input  wire logic                     resetn_in,
	input  wire logic                     load_en_in,
	input  wire logic [$clog2(WORDS)-1:0] load_idx_in,
	input  wire logic [WIDTH-1:0]         load_data_in,
	input  wire logic                     clear_in,
	input  wire logic [$clog2(WORDS)-1:0] rd_idx_in,
	output logic      [WIDTH-1:0]         rd_data_out,
	output logic      [WORDS-1:0]         loaded_out
);
	`include "flash_seq_regs.svh"

	logic [WIDTH-1:0] latch_r [WORDS];
	logic [WORDS-1:0] loaded_r;

	// elaboration check
	initial
	begin
		if (WORDS < 2 || WIDTH != 14)
			$error("latch_bank: unsupported geometry");
	end

	// clear back to blank after every finished program or erase; a load only operation returns to idle without clearing
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (int i = 0; i < WORDS; i++)
				latch_r[i] <= `LATCH_BLANK;
			loaded_r <= '0;
		end
		else if (clear_in)
		begin
			for (int i = 0; i < WORDS; i++)
				latch_r[i] <= `LATCH_BLANK;
			loaded_r <= '0;
		end
		else if (load_en_in)
		begin
			latch_r[load_idx_in]  <= load_data_in;
			loaded_r[load_idx_in] <= 1'b1;
		end
	end

	assign rd_data_out = latch_r[rd_idx_in];
	assign loaded_out  = loaded_r;

endmodule

// ### testbench/tb_flash_row_write_latch_sequencer.sv
// self-checking bench for the flash row write latch sequencer
`timescale 1ns/1ns
`include "flash_seq_regs.svh"
module tb_flash_row_write_latch_sequencer;
	import flash_seq_pkg::*;

	// ****************************************
	// signals and scoreboard queues
	// ****************************************
	logic        clk_in;
	logic        resetn_in;
	logic [4:0]  avs_address_in;
	logic        avs_read_in;
	logic        avs_write_in;
	logic [31:0] avs_writedata_in;
	logic [3:0]  avs_byteenable_in;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [9:0]  wp_rows_in;
	flash_cmd_t  flash_cmd_out;
	logic        flash_req_out;
	logic        flash_ack_in;
	logic        irq_out;
	int          mismatches;
	int          cmp_count;
	int          ack_dly;
	logic [31:0] rd_q[$];
	logic [30:0] cmd_q[$];
	logic [30:0] msk_q[$];
	logic [9:0]  row;
	logic [13:0] d0;
	logic [13:0] d5;
	logic [13:0] d31;

	// control values; region select left clear for the main array
	localparam logic [7:0] C_WE = 8'h01 << `CTL_WRITE_EN;
	localparam logic [7:0] C_LO = 8'h01 << `CTL_LOAD_ONLY;
	localparam logic [7:0] C_ER = 8'h01 << `CTL_ROW_ERASE;
	localparam logic [7:0] C_GO = 8'h01 << `CTL_WRITE_START;
	localparam logic [7:0] C_WERR = 8'h01 << `CTL_WRITE_ERR;
	localparam logic [7:0] C_RS = 8'h01 << `CTL_REGION_SEL;

	flash_row_write_latch_sequencer #(.WORDS(32)) dut_u (
		.clk_in              (clk_in),
		.resetn_in           (resetn_in),
		.avs_address_in      (avs_address_in),
		.avs_read_in         (avs_read_in),
		.avs_write_in        (avs_write_in),
		.avs_writedata_in    (avs_writedata_in),
		.avs_byteenable_in   (avs_byteenable_in),
		.avs_readdata_out    (avs_readdata_out),
		.avs_waitrequest_out (avs_waitrequest_out),
		.wp_rows_in          (wp_rows_in),
		.flash_cmd_out       (flash_cmd_out),
		.flash_req_out       (flash_req_out),
		.flash_ack_in        (flash_ack_in),
		.irq_out             (irq_out)
	);

	// free-running 100 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ****************************************
	// compare, verdict and bus tasks
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp,
		input logic [31:0] msk);
		cmp_count++;
		if ((seen & msk) !== (exp & msk))
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp & msk, seen & msk);
		end
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// waits for waitrequest low, bounded so a stuck slave ends the run
	task automatic bus_wait();
		int   n;
		logic w;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
			w = avs_waitrequest_out;
		end
		while (w !== 1'b0 && n < 20);
		if (w !== 1'b0)
		begin
			mismatches++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
		@(posedge clk_in);
		avs_write_in      <= 1'b1;
		avs_address_in    <= a;
		avs_writedata_in  <= {24'h000000, d};
		avs_byteenable_in <= be;
		bus_wait();
		avs_write_in <= 1'b0;
	endtask

	// expected read data is queued before the request goes out
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		@(posedge clk_in);
		avs_read_in    <= 1'b1;
		avs_address_in <= a;
		bus_wait();
		avs_read_in <= 1'b0;
	endtask

	// key pair then start; nothing else may be written in between
	task automatic unlock(input logic [7:0] ctl);
		wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_1);
		wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_2);
		wr(`OFS_CONTROL, ctl | C_GO);
	endtask

	// address and data placed first, address set by hand each word
	task automatic load(input logic [9:0] r, input logic [4:0] idx, input logic [13:0] d,
		input logic [7:0] ctl);
		wr(`OFS_ADDR_LOW, {r[2:0], idx});
		wr(`OFS_ADDR_HIGH, {1'b0, r[9:3]});
		wr(`OFS_DATA_LOW, d[7:0]);
		wr(`OFS_DATA_HIGH, {2'b00, d[13:8]});
		unlock(ctl);
	endtask

	task automatic exp_cmd(input logic e, input logic [9:0] r, input logic [4:0] idx,
		input logic [13:0] d, input logic [30:0] m);
		cmd_q.push_back({e, 1'b0, r, idx, d});
		msk_q.push_back(m);
	endtask

	task automatic irq_is(input logic exp);
		repeat (2) @(posedge clk_in);
		check("irq_out", {31'h0, irq_out}, {31'h0, exp}, 32'h00000001);
	endtask

	// bounded wait for the done interrupt, then status read and cleared
	task automatic wait_done();
		int   n;
		logic q;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
			q = irq_out;
		end
		while (q !== 1'b1 && n < 300);
		if (q !== 1'b1)
		begin
			mismatches++;
			wrap_up();
		end
		rd(`OFS_IRQ_STATUS, 32'h00000001);
		wr(`OFS_IRQ_STATUS, 8'h01);
	endtask

	// ****************************************
	// far side of the flash link and monitor
	// ****************************************
	// array answers after a random delay of 0..3 cycles
	// it holds no contents, so every row programmed counts as never written
	always @(posedge clk_in)
	begin
		if (flash_ack_in)
			flash_ack_in <= 1'b0;
		else if (flash_req_out === 1'b1 && ack_dly == 0)
		begin
			flash_ack_in <= 1'b1;
			ack_dly      <= $urandom_range(3, 0);
		end
		else if (flash_req_out === 1'b1)
			ack_dly <= ack_dly - 1;
	end

	// an unexpected result meets an unknown note and always mismatches
	always @(posedge clk_in)
	begin
		if (resetn_in && avs_read_in && avs_waitrequest_out === 1'b0)
			check("readdata", avs_readdata_out,
				rd_q.size() > 0 ? rd_q.pop_front() : 32'hXXXXXXXX, 32'hFFFFFFFF);
		if (resetn_in && flash_req_out === 1'b1 && flash_ack_in)
			check("flash_cmd", {1'b0, flash_cmd_out},
				cmd_q.size() > 0 ? {1'b0, cmd_q.pop_front()} : 32'hXXXXXXXX,
				msk_q.size() > 0 ? {1'b0, msk_q.pop_front()} : 32'hFFFFFFFF);
	end

	// hang guard
	initial
	begin
		repeat (60000) @(posedge clk_in);
		mismatches++;
		wrap_up();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		mismatches        = 0;
		cmp_count         = 0;
		ack_dly           = 2;
		resetn_in         = 1'b0;
		avs_address_in    = 5'h00;
		avs_read_in       = 1'b0;
		avs_write_in      = 1'b0;
		avs_writedata_in  = 32'h00000000;
		avs_byteenable_in = 4'h0;
		wp_rows_in        = 10'h004;
		flash_ack_in      = 1'b0;
		void'($urandom(51));
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		// reset values, unmapped place, write without byte lane
		for (int i = 0; i < 8; i++)
			rd(5'(i * 4), 32'h00000000);
		wr(5'h01, 8'h5A);
		wr(`OFS_ADDR_LOW, 8'hA5, 4'h0);
		rd(5'h01, 32'h00000000);
		rd(`OFS_ADDR_LOW, 32'h00000000);
		wr(`OFS_IRQ_MASK, 8'h01);
		// partial row: latches 0 and 5 loaded, 31 loads and programs
		row = 10'($urandom_range(1023, 4));
		d0  = 14'($urandom);
		d5  = 14'($urandom);
		d31 = 14'($urandom);
		load(row, 5'h00, d0, C_WE | C_LO);
		load(row, 5'h05, d5, C_WE | C_LO);
		irq_is(1'b0);
		exp_cmd(1'b0, row, 5'h00, d0, 31'h7FFFFFFF);
		exp_cmd(1'b0, row, 5'h05, d5, 31'h7FFFFFFF);
		exp_cmd(1'b0, row, 5'h1F, d31, 31'h7FFFFFFF);
		load(row, 5'h1F, d31, C_WE);
		rd(`OFS_CONTROL, {24'h000000, C_WE | C_GO});
		wait_done();
		// interrupt masking and clearing
		wr(`OFS_IRQ_MASK, 8'h00);
		wr(`OFS_IRQ_STATUS, 8'h00);
		irq_is(1'b0);
		// second row: earlier latches must have gone blank
		row = 10'($urandom_range(1023, 4));
		d31 = 14'($urandom);
		exp_cmd(1'b0, row, 5'h1F, d31, 31'h7FFFFFFF);
		load(row, 5'h1F, d31, C_WE);
		repeat (60) @(posedge clk_in);
		irq_is(1'b0);
		wr(`OFS_IRQ_MASK, 8'h01);
		irq_is(1'b1);
		wr(`OFS_IRQ_STATUS, 8'h01);
		irq_is(1'b0);
		// row erase: one command at the row base, data ignored
		row = 10'($urandom_range(1023, 4));
		exp_cmd(1'b1, row, 5'h00, 14'h0000, 31'h7FFFC000);
		load(row, 5'h09, 14'h1234, C_WE | C_ER);
		wait_done();
		// user id space: region select with a low address programs one word
		d0 = 14'($urandom);
		cmd_q.push_back({1'b0, 1'b1, 10'h000, 5'h02, d0});
		msk_q.push_back(31'h7FFFFFFF);
		load(10'h000, 5'h02, d0, C_WE | C_RS);
		wait_done();
		// keys in the wrong order start nothing
		wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_2);
		wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_1);
		wr(`OFS_CONTROL, C_WE | C_GO);
		wr(`OFS_CONTROL, C_WE);
		wr(`OFS_IRQ_STATUS, 8'h02);
		// another write between keys aborts and flags an error
		wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_1);
		wr(`OFS_DATA_LOW, 8'h3C);
		wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_2);
		wr(`OFS_CONTROL, C_WE | C_GO);
		rd(`OFS_IRQ_STATUS, 32'h00000002);
		wr(`OFS_IRQ_STATUS, 8'h02);
		rd(`OFS_IRQ_STATUS, 32'h00000000);
		// protected row refuses to program
		load(10'h001, 5'h03, 14'h2AAA, C_WE);
		rd(`OFS_CONTROL, {24'h000000, C_WE | C_WERR});
		rd(`OFS_IRQ_STATUS, 32'h00000002);
		wr(`OFS_CONTROL, C_WE);
		rd(`OFS_CONTROL, {24'h000000, C_WE});
		// user id space above the last id word is refused
		load(10'h000, 5'h05, 14'h0155, C_WE | C_RS);
		rd(`OFS_CONTROL, {24'h000000, C_WE | C_RS | C_WERR});
		repeat (20) @(posedge clk_in);
		check("cmd_left", 32'(cmd_q.size()), 32'h00000000, 32'hFFFFFFFF);
		check("rd_left", 32'(rd_q.size()), 32'h00000000, 32'hFFFFFFFF);
		wrap_up();
	end
endmodule
